// ### tcm_pkg.sv
package tcm_pkg;

	// Register map, byte addresses on the plain register port.
	localparam int          REG_AW        = 4;
	localparam logic [3:0]  MODE_OFFS     = 4'h0;
	localparam logic [3:0]  CMP3_OFFS     = 4'h4;
	localparam logic [3:0]  STAT_OFFS     = 4'h8;
	localparam logic [15:0] MODE_RESET    = 16'h0000;
	localparam logic [15:0] CMP3_RESET    = 16'h0000;

	// Field positions inside the channel pair mode register.
	localparam int CH4_FILT_LSB  = 12;
	localparam int CH4_DIV_LSB   = 10;
	localparam int CH4_DIR_LSB   = 8;
	localparam int CH3_FILT_LSB  = 4;
	localparam int CH3_DIV_LSB   = 2;
	localparam int CH3_DIR_LSB   = 0;
	localparam int CH3_CMODE_LSB = 4;
	localparam int CH3_BUF_BIT   = 3;
	localparam int CH3_FAST_BIT  = 2;

	// Status register bit positions.
	localparam int STAT_CH3_LVL  = 0;
	localparam int STAT_CH4_LVL  = 1;
	localparam int STAT_REF3     = 2;

	// Direction select codes.
	localparam logic [1:0] DIR_OUTPUT = 2'h0;
	localparam logic [1:0] DIR_OWN    = 2'h1;
	localparam logic [1:0] DIR_OTHER  = 2'h2;
	localparam logic [1:0] DIR_TRIG   = 2'h3;

	// Compare mode codes.
	localparam logic [2:0] CM_FROZEN  = 3'h0;
	localparam logic [2:0] CM_SET     = 3'h1;
	localparam logic [2:0] CM_CLEAR   = 3'h2;
	localparam logic [2:0] CM_TOGGLE  = 3'h3;
	localparam logic [2:0] CM_FORCE0  = 3'h4;
	localparam logic [2:0] CM_FORCE1  = 3'h5;
	localparam logic [2:0] CM_PWM1    = 3'h6;
	localparam logic [2:0] CM_PWM2    = 3'h7;

	// Filter code that bypasses filtering.
	localparam logic [3:0] FILT_NONE  = 4'h0;

endpackage

// ### tcm_mode_config.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// How it works
// - Channel 4 filter is bits 15:12, used only when channel 4 is an input.
// - Filtered level changes only after N consecutive equal samples at chosen rate.
// - Filter code 0 samples every clock with no filtering.
// - Codes 1,2,3 sample every clock needing 2, 4, 8 samples.
// - Codes 4,5 sample at half rate, 6,7 at quarter; N is 6 or 8.
// - Codes 8,9 sample at one eighth rate needing 6 or 8 samples.
// - Codes 10,11,12 sample at one sixteenth needing 5, 6, 8 samples.
// - Codes 13,14,15 sample at one thirty-second needing 5, 6, 8 samples.
// - Capture divider captures on every 1st, 2nd, 4th or 8th edge.
// - Channel 3 filter is bits 7:4, same coding, input mode only.
// - Channel 3 capture divider is bits 3:2, input mode only.
// - Channel 4 direction: output, input four, input three, internal trigger.
// - Channel 3 direction: output, input three, input four, internal trigger.
// - Channel 3 compare mode is bits 6:4, used only as an output.
// - Channel 3 buffer bit 3 and fast bit 2 apply only as output; bit 3 also gates compare writes in input mode.
// - Compare modes: frozen, set, clear, toggle, force low, force high, PWM1, PWM2.
// - Buffered compare value loads on update event; unbuffered writes act at once.
// - Fast enable in PWM makes a trigger edge act as a match.
module tcm_mode_config
	import tcm_pkg::*;
(
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	input  wire logic [tcm_pkg::REG_AW-1:0]  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata,
	input  wire logic                        timer_input_three,
	input  wire logic                        timer_input_four,
	input  wire logic                        internal_trigger_input,
	input  wire logic                        ch3_channel_enable,
	input  wire logic                        ch4_channel_enable,
	input  wire logic [15:0]                 counter_value,
	input  wire logic                        count_down,
	input  wire logic                        update_event,
	output logic                             ch3_capture,
	output logic                             ch4_capture,
	output logic                             ch3_filtered,
	output logic                             ch4_filtered,
	output logic                             ch3_reference_out
);
	import tcm_pkg::*;

	// Required sample count for a filter code, zero meaning no filter.
	function automatic logic [3:0] filt_len(input logic [3:0] code);
		case (code)
			4'h0: filt_len = 4'h0;
			4'h1: filt_len = 4'h2;
			4'h2: filt_len = 4'h4;
			4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filt_len = 4'h6;
			4'hA, 4'hD: filt_len = 4'h5;
			default: filt_len = 4'h8;
		endcase
	endfunction

	// Mask on the free prescaler giving the sampling rate of a filter code.
	function automatic logic [4:0] filt_mask(input logic [3:0] code);
		case (code)
			4'h4, 4'h5: filt_mask = 5'h01;
			4'h6, 4'h7: filt_mask = 5'h03;
			4'h8, 4'h9: filt_mask = 5'h07;
			4'hA, 4'hB, 4'hC: filt_mask = 5'h0F;
			4'hD, 4'hE, 4'hF: filt_mask = 5'h1F;
			default: filt_mask = 5'h00;
		endcase
	endfunction

	// Last event count before a capture for a divider code.
	function automatic logic [2:0] div_last(input logic [1:0] code);
		case (code)
			2'h0: div_last = 3'h0;
			2'h1: div_last = 3'h1;
			2'h2: div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction

	// Source picked by a direction code: own pin, partner pin or trigger.
	function automatic logic src_pick(input logic [1:0] dir, input logic own,
			input logic other, input logic trig);
		case (dir)
			DIR_OWN: src_pick = own;
			DIR_OTHER: src_pick = other;
			DIR_TRIG: src_pick = trig;
			default: src_pick = 1'b0;
		endcase
	endfunction

	logic [15:0] mode_reg;
	logic [15:0] cmp_buf;
	logic [15:0] cmp_shadow;
	logic [2:0]  pin_meta;
	logic [2:0]  pin_sync;
	logic        trig_d;
	logic        trig_edge;
	logic [4:0]  pre_cnt;
	logic [3:0]  filt_code [2];
	logic [1:0]  div_code [2];
	logic [1:0]  dir_code [2];
	logic        chan_en [2];
	logic        ch_src [2];
	logic        flt_lvl [2];
	logic        flt_lvl_d [2];
	logic [2:0]  flt_cnt [2];
	logic [2:0]  ev_cnt [2];
	logic        cap [2];
	logic [2:0]  cmode;
	logic        buf_en;
	logic        fast_en;
	logic        is_pwm;
	logic        match;

	// Field decode of the mode register.
	assign filt_code[0] = mode_reg[CH3_FILT_LSB +: 4];
	assign filt_code[1] = mode_reg[CH4_FILT_LSB +: 4];
	assign div_code[0]  = mode_reg[CH3_DIV_LSB +: 2];
	assign div_code[1]  = mode_reg[CH4_DIV_LSB +: 2];
	assign dir_code[0]  = mode_reg[CH3_DIR_LSB +: 2];
	assign dir_code[1]  = mode_reg[CH4_DIR_LSB +: 2];
	assign chan_en[0]   = ch3_channel_enable;
	assign chan_en[1]   = ch4_channel_enable;
	assign cmode        = mode_reg[CH3_CMODE_LSB +: 3];
	assign buf_en       = mode_reg[CH3_BUF_BIT];
	assign fast_en      = mode_reg[CH3_FAST_BIT];
	assign is_pwm       = (cmode == CM_PWM1) || (cmode == CM_PWM2);
	assign match        = (counter_value == cmp_shadow);

	// Input source routing per channel direction.
	assign ch_src[0] = src_pick(dir_code[0], pin_sync[0], pin_sync[1], pin_sync[2]);
	assign ch_src[1] = src_pick(dir_code[1], pin_sync[1], pin_sync[0], pin_sync[2]);
	assign trig_edge = pin_sync[2] & ~trig_d;

	// Mode register; direction fields hold while their channel is enabled.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_reg <= MODE_RESET;
		end else if (reg_wr && reg_addr == MODE_OFFS) begin
			mode_reg <= reg_wdata[15:0];
			if (ch3_channel_enable) begin
				mode_reg[CH3_DIR_LSB +: 2] <= mode_reg[CH3_DIR_LSB +: 2];
			end
			if (ch4_channel_enable) begin
				mode_reg[CH4_DIR_LSB +: 2] <= mode_reg[CH4_DIR_LSB +: 2];
			end
		end
	end

	// Compare value: buffer written by software, shadow used by the match.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmp_buf <= CMP3_RESET;
			cmp_shadow <= CMP3_RESET;
		end else begin
			if (reg_wr && reg_addr == CMP3_OFFS) begin
				cmp_buf <= reg_wdata[15:0];
				if (!buf_en) begin
					cmp_shadow <= reg_wdata[15:0];
				end
			end
			if (update_event && buf_en) begin
				cmp_shadow <= cmp_buf;
			end
		end
	end

	// Read port: data stand in the cycle after the read strobe.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				MODE_OFFS: reg_rdata <= {16'h0, mode_reg};
				CMP3_OFFS: reg_rdata <= {16'h0, buf_en ? cmp_buf : cmp_shadow};
				STAT_OFFS: begin
					reg_rdata <= 32'h0;
					reg_rdata[STAT_CH3_LVL] <= flt_lvl[0];
					reg_rdata[STAT_CH4_LVL] <= flt_lvl[1];
					reg_rdata[STAT_REF3] <= ch3_reference_out;
				end
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// Two-stage synchronisers for the pins, then trigger edge history.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
			trig_d <= 1'b0;
		end else begin
			pin_meta <= {internal_trigger_input, timer_input_four, timer_input_three};
			pin_sync <= pin_meta;
			trig_d <= pin_sync[2];
		end
	end

	// Free prescaler that sets the slower sampling rates.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pre_cnt <= 5'h0;
		end else begin
			pre_cnt <= pre_cnt + 5'h1;
		end
	end

	// Digital filter per channel.
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 2; i++) begin
			if (sys_rst) begin
				flt_lvl[i] <= 1'b0;
				flt_cnt[i] <= 3'h0;
			end else if (filt_code[i] == FILT_NONE) begin
				flt_lvl[i] <= ch_src[i];
				flt_cnt[i] <= 3'h0;
			end else if ((pre_cnt & filt_mask(filt_code[i])) == 5'h0) begin
				if (ch_src[i] == flt_lvl[i]) begin
					flt_cnt[i] <= 3'h0;
				end else if ({1'b0, flt_cnt[i]} == filt_len(filt_code[i]) - 4'h1) begin
					flt_lvl[i] <= ch_src[i];
					flt_cnt[i] <= 3'h0;
				end else begin
					flt_cnt[i] <= flt_cnt[i] + 3'h1;
				end
			end
		end
	end

	// Edge detection and capture divider; only input-mode, enabled channels count.
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 2; i++) begin
			if (sys_rst) begin
				flt_lvl_d[i] <= 1'b0;
				ev_cnt[i] <= 3'h0;
				cap[i] <= 1'b0;
			end else begin
				flt_lvl_d[i] <= flt_lvl[i];
				cap[i] <= 1'b0;
				if (dir_code[i] == DIR_OUTPUT || !chan_en[i]) begin
					ev_cnt[i] <= 3'h0;
				end else if (flt_lvl[i] && !flt_lvl_d[i]) begin
					if (ev_cnt[i] == div_last(div_code[i])) begin
						ev_cnt[i] <= 3'h0;
						cap[i] <= 1'b1;
					end else begin
						ev_cnt[i] <= ev_cnt[i] + 3'h1;
					end
				end
			end
		end
	end

	// Channel 3 output reference, held low while the channel is an input.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ch3_reference_out <= 1'b0;
		end else if (dir_code[0] != DIR_OUTPUT) begin
			ch3_reference_out <= 1'b0;
		end else if (fast_en && is_pwm && trig_edge) begin
			ch3_reference_out <= (cmode == CM_PWM2);
		end else begin
			case (cmode)
				CM_FROZEN: ch3_reference_out <= ch3_reference_out;
				CM_SET: ch3_reference_out <= ch3_reference_out | match;
				CM_CLEAR: ch3_reference_out <= ch3_reference_out & ~match;
				CM_TOGGLE: ch3_reference_out <= ch3_reference_out ^ match;
				CM_FORCE0: ch3_reference_out <= 1'b0;
				CM_FORCE1: ch3_reference_out <= 1'b1;
				CM_PWM1: ch3_reference_out <= count_down ? !(counter_value > cmp_shadow)
					: (counter_value < cmp_shadow);
				CM_PWM2: ch3_reference_out <= count_down ? (counter_value > cmp_shadow)
					: !(counter_value < cmp_shadow);
				default: ch3_reference_out <= 1'b0;
			endcase
		end
	end

	assign ch3_capture  = cap[0];
	assign ch4_capture  = cap[1];
	assign ch3_filtered = flt_lvl[0];
	assign ch4_filtered = flt_lvl[1];

	// Checks on the block's own behaviour.
	property p_bypass;
		@(posedge clk_sys) disable iff (sys_rst)
		(filt_code[1] == FILT_NONE) |=> (flt_lvl[1] == $past(ch_src[1]));
	endproperty
	a_bypass: assert property (p_bypass) else $error("Unfiltered level lags source.");

	property p_filter_len;
		@(posedge clk_sys) disable iff (sys_rst)
		($changed(flt_lvl[0]) && $past(filt_code[0]) != FILT_NONE
			&& $stable(filt_code[0]))
		|-> ({1'b0, $past(flt_cnt[0])} == filt_len(filt_code[0]) - 4'h1);
	endproperty
	a_filter_len: assert property (p_filter_len) else $error("Filter moved early.");

	property p_restart;
		@(posedge clk_sys) disable iff (sys_rst)
		(filt_code[1] != FILT_NONE && ch_src[1] == flt_lvl[1]
			&& (pre_cnt & filt_mask(filt_code[1])) == 5'h0) |=> (flt_cnt[1] == 3'h0);
	endproperty
	a_restart: assert property (p_restart) else $error("Sample count not restarted.");

	property p_divider;
		@(posedge clk_sys) disable iff (sys_rst)
		cap[0] |-> ($past(ev_cnt[0]) == div_last($past(div_code[0])));
	endproperty
	a_divider: assert property (p_divider) else $error("Capture off divider count.");

	property p_output_no_capture;
		@(posedge clk_sys) disable iff (sys_rst)
		($past(dir_code[1]) == DIR_OUTPUT) |-> !cap[1];
	endproperty
	a_output_no_capture: assert property (p_output_no_capture) else $error("Output captured.");

	property p_shadow_load;
		@(posedge clk_sys) disable iff (sys_rst)
		(update_event && buf_en) |=> (cmp_shadow == $past(cmp_buf));
	endproperty
	a_shadow_load: assert property (p_shadow_load) else $error("Shadow not loaded.");

	property p_force;
		@(posedge clk_sys) disable iff (sys_rst)
		(dir_code[0] == DIR_OUTPUT && cmode == CM_FORCE1) |=> ch3_reference_out;
	endproperty
	a_force: assert property (p_force) else $error("Forced level missing.");

	property p_fast;
		@(posedge clk_sys) disable iff (sys_rst)
		(dir_code[0] == DIR_OUTPUT && fast_en && cmode == CM_PWM2 && trig_edge)
		|=> ch3_reference_out;
	endproperty
	a_fast: assert property (p_fast) else $error("Fast trigger ignored.");

	property p_input_ref;
		@(posedge clk_sys) disable iff (sys_rst)
		(dir_code[0] != DIR_OUTPUT) |=> !ch3_reference_out;
	endproperty
	a_input_ref: assert property (p_input_ref) else $error("Reference driven as input.");

	property p_field_read;
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd && reg_addr == MODE_OFFS) |=> (reg_rdata[15:12] == $past(filt_code[1]));
	endproperty
	a_field_read: assert property (p_field_read) else $error("Filter field misread.");

	c_capture4: cover property (@(posedge clk_sys) disable iff (sys_rst) cap[1]);
	c_div8: cover property (@(posedge clk_sys) disable iff (sys_rst)
		cap[0] && div_code[0] == 2'h3);
	c_slow_filter: cover property (@(posedge clk_sys) disable iff (sys_rst)
		$changed(flt_lvl[0]) && filt_code[0] == 4'hF);
	c_fast: cover property (@(posedge clk_sys) disable iff (sys_rst)
		fast_en && is_pwm && trig_edge && dir_code[0] == DIR_OUTPUT);

endmodule

// ### tcm_pin_model.sv
`timescale 1ns/1ps
module tcm_pin_model (
	input  wire logic want_three,
	input  wire logic want_four,
	input  wire logic want_trig,
	input  wire logic clk_sys,
	output logic      timer_input_three,
	output logic      timer_input_four,
	output logic      internal_trigger_input
);
	// Pins start low so the synchronisers never see an unknown level.
	initial begin
		timer_input_three = 1'b0;
		timer_input_four = 1'b0;
		internal_trigger_input = 1'b0;
	end
	// Each pin follows its request at the falling edge, away from the sampling edge.
	always @(negedge clk_sys) begin
		timer_input_three <= want_three;
		timer_input_four <= want_four;
		internal_trigger_input <= want_trig;
	end
endmodule

// ### tcm_mode_config_tb.sv
`timescale 1ns/1ps
module tcm_mode_config_tb;
	import tcm_pkg::*;
	logic              clk_sys = 1'b0;
	logic              sys_rst = 1'b1;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              update_event = 1'b0;
	logic              count_down = 1'b0;
	logic              ch3_channel_enable = 1'b0;
	logic              ch4_channel_enable = 1'b0;
	logic              want3 = 1'b0;
	logic              want4 = 1'b0;
	logic              wtrig = 1'b0;
	logic              g;
	logic [REG_AW-1:0] reg_addr = 4'h0;
	logic [31:0]       reg_wdata = 32'h0;
	logic [15:0]       counter_value = 16'h0;
	logic [31:0]       reg_rdata;
	logic              ch3_capture, ch4_capture, ch3_filtered, ch4_filtered, ch3_reference_out;
	logic              timer_input_three, timer_input_four, internal_trigger_input;
	int                n_errors = 0;
	int                comparisons = 0;
	int                cap3 = 0;
	int                cap4 = 0;
	int                t;
	int                rate[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
	int                len[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};

	// Device and the model of its external sources.
	tcm_mode_config tcm_mode_config_i (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .timer_input_three, .timer_input_four, .internal_trigger_input,
		.ch3_channel_enable, .ch4_channel_enable, .counter_value, .count_down, .update_event,
		.ch3_capture, .ch4_capture, .ch3_filtered, .ch4_filtered, .ch3_reference_out);
	tcm_pin_model tcm_pin_model_i (.want_three(want3), .want_four(want4), .want_trig(wtrig),
		.clk_sys, .timer_input_three, .timer_input_four, .internal_trigger_input);

	// Clock at 25 MHz.
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	// Counts capture pulses seen on both channels.
	always @(posedge clk_sys) begin
		if (ch3_capture === 1'b1) cap3 <= cap3 + 1;
		if (ch4_capture === 1'b1) cap4 <= cap4 + 1;
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s: got %b expected %b", $time, m, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken just then.
	task automatic rdchk(input logic [REG_AW-1:0] a, input logic [31:0] exp, input string m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk32(reg_rdata, exp, m);
	endtask
	task automatic pins(input logic a, input logic b, input logic c);
		want3 <= a;
		want4 <= b;
		wtrig <= c;
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			pins(1'b1, 1'b1, 1'b0);
			cyc(4);
			pins(1'b0, 1'b0, 1'b0);
			cyc(4);
		end
	endtask
	task automatic step(input logic [2:0] m, input logic [1:0] bf, input logic [15:0] cv,
		input logic exp, input string s);
		counter_value <= cv;
		wr(MODE_OFFS, {25'h0, m, bf, 2'b00});
		cyc(3);
		#1 chk1(ch3_reference_out, exp, s);
	endtask
	task automatic done(input string s);
		$display("Test %s finished, %0d mismatches so far", s, n_errors);
	endtask
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Cuts a hang short well after the tests should have ended.
	initial begin
		cyc(20000);
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		final_report;
	end

	// Main sequence of tests.
	initial begin
		cyc(8);
		sys_rst <= 1'b0;
		rdchk(MODE_OFFS, {16'h0, MODE_RESET}, "mode reset");
		rdchk(CMP3_OFFS, {16'h0, CMP3_RESET}, "compare reset");
		wr(MODE_OFFS, 32'hFFFF_FFFF);
		rdchk(MODE_OFFS, 32'h0000_FFFF, "mode fields");
		wr(4'hC, 32'h0000_5A5A);
		rdchk(4'hC, 32'h0, "unmapped");
		ch3_channel_enable <= 1'b1;
		wr(MODE_OFFS, 32'h0);
		rdchk(MODE_OFFS, 32'h0000_0003, "direction held");
		ch3_channel_enable <= 1'b0;
		done("registers");
		// Every filter code on both channels: short pulse rejected for codes 1 to 15, steady level passed.
		for (int c = 0; c < 16; c++) begin
			wr(MODE_OFFS, {16'h0, 4'(c), 4'h1, 4'(c), 4'h1});
			if (len[c] > 1) begin
				pins(1'b1, 1'b1, 1'b0);
				cyc((len[c] - 1) * rate[c]);
				pins(1'b0, 1'b0, 1'b0);
				g = 1'b0;
				repeat (len[c] * rate[c] + 8) begin
					@(posedge clk_sys);
					#1 g = g | ch3_filtered | ch4_filtered;
				end
				chk1(g, 1'b0, "short pulse passed");
			end
			pins(1'b1, 1'b1, 1'b0);
			t = 0;
			do begin
				@(posedge clk_sys);
				#1 t++;
			end while (!(ch3_filtered && ch4_filtered) && t < len[c] * rate[c] + 8);
			chk1(ch3_filtered & ch4_filtered, 1'b1, "filter rise");
			chk1(t >= (len[c] - 1) * rate[c] + 3, 1'b1, "early");
			if (c == 0) chk1(t == 3, 1'b1, "bypass delay");
			pins(1'b0, 1'b0, 1'b0);
			cyc(len[c] * rate[c] + rate[c] + 8);
			#1 chk1(ch3_filtered | ch4_filtered, 1'b0, "filter fall");
		end
		done("filter");
		for (int d = 1; d < 4; d++) begin
			wr(MODE_OFFS, {22'h0, 2'(d), 6'h0, 2'(d)});
			for (int p = 0; p < 3; p++) begin
				pins(p == 0, p == 1, p == 2);
				cyc(6);
				rdchk(STAT_OFFS, {30'h0, p == ((d == 1) ? 1 : (d == 2) ? 0 : 2), p == d - 1},
					"source");
			end
			pins(1'b0, 1'b0, 1'b0);
		end
		done("source select");
		for (int v = 0; v < 4; v++) begin
			wr(MODE_OFFS, {20'h0, 2'(v), 2'h1, 4'h0, 2'(v), 2'h1});
			ch3_channel_enable <= 1'b1;
			ch4_channel_enable <= 1'b1;
			cap3 <= 0;
			cap4 <= 0;
			pulses(8);
			chk32(32'(cap3), 32'(8 >> v), "ch3 captures");
			chk32(32'(cap4), 32'(8 >> v), "ch4 captures");
			ch3_channel_enable <= 1'b0;
			ch4_channel_enable <= 1'b0;
		end
		wr(MODE_OFFS, 32'h0);
		ch3_channel_enable <= 1'b1;
		ch4_channel_enable <= 1'b1;
		cap3 <= 0;
		cap4 <= 0;
		pulses(8);
		chk32(32'(cap3 + cap4), 32'h0, "capture as output");
		done("divider");
		wr(CMP3_OFFS, 32'h0000_0040);
		step(CM_FORCE1, 2'b00, 16'h0010, 1'b1, "force active");
		step(CM_FORCE0, 2'b00, 16'h0010, 1'b0, "force inactive");
		step(CM_FROZEN, 2'b00, 16'h0040, 1'b0, "frozen");
		step(CM_SET, 2'b00, 16'h0040, 1'b1, "set on match");
		step(CM_CLEAR, 2'b00, 16'h0040, 1'b0, "clear on match");
		step(CM_FROZEN, 2'b00, 16'h0010, 1'b0, "frozen hold");
		step(CM_PWM1, 2'b00, 16'h0010, 1'b1, "pwm1 below");
		step(CM_PWM1, 2'b00, 16'h0050, 1'b0, "pwm1 above");
		step(CM_FROZEN, 2'b00, 16'h0050, 1'b0, "frozen hold");
		step(CM_PWM2, 2'b00, 16'h0050, 1'b1, "pwm2 above");
		step(CM_PWM2, 2'b00, 16'h0010, 1'b0, "pwm2 below");
		step(CM_TOGGLE, 2'b00, 16'h0010, 1'b0, "toggle idle");
		counter_value <= 16'h0040;
		@(posedge clk_sys);
		counter_value <= 16'h0010;
		cyc(3);
		#1 chk1(ch3_reference_out, 1'b1, "toggle");
		ch3_channel_enable <= 1'b0;
		wr(MODE_OFFS, 32'h1);
		cyc(2);
		#1 chk1(ch3_reference_out, 1'b0, "input mode reference");
		wr(MODE_OFFS, 32'h0);
		step(CM_PWM1, 2'b10, 16'h0050, 1'b0, "pwm1 buffered");
		wr(CMP3_OFFS, 32'h0000_0060);
		rdchk(CMP3_OFFS, 32'h0000_0060, "buffer read");
		chk1(ch3_reference_out, 1'b0, "shadow kept");
		update_event <= 1'b1;
		@(posedge clk_sys);
		update_event <= 1'b0;
		cyc(3);
		#1 chk1(ch3_reference_out, 1'b1, "update load");
		rdchk(STAT_OFFS, 32'h0000_0004, "reference status");
		step(CM_PWM1, 2'b00, 16'h0050, 1'b1, "unbuffered");
		wr(CMP3_OFFS, 32'h0000_0030);
		cyc(2);
		#1 chk1(ch3_reference_out, 1'b0, "direct write");
		step(CM_PWM1, 2'b01, 16'h0010, 1'b1, "fast armed");
		pins(1'b0, 1'b0, 1'b1);
		t = 0;
		do begin
			@(posedge clk_sys);
			#1 t++;
		end while (ch3_reference_out !== 1'b0 && t < 8);
		chk1(t == 3, 1'b1, "fast trigger delay");
		pins(1'b0, 1'b0, 1'b0);
		step(CM_PWM2, 2'b01, 16'h0010, 1'b0, "fast pwm2 armed");
		pins(1'b0, 1'b0, 1'b1);
		t = 0;
		do begin
			@(posedge clk_sys);
			#1 t++;
		end while (ch3_reference_out !== 1'b1 && t < 8);
		chk1(t == 3, 1'b1, "fast pwm2 delay");
		pins(1'b0, 1'b0, 1'b0);
		// Down counting flips the result at equality, so equal values tell the two apart.
		count_down <= 1'b1;
		step(CM_PWM1, 2'b00, 16'h0030, 1'b1, "pwm1 down equal");
		step(CM_PWM2, 2'b00, 16'h0030, 1'b0, "pwm2 down equal");
		count_down <= 1'b0;
		done("compare");
		final_report;
	end
endmodule
